// File: common/ucg_consts.vh
`ifndef UCG_CONSTS_VH
`define UCG_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define UCG_OFF_P2_FRAC 12'h19c
`define UCG_OFF_P3_SRCDIV 12'h1a0
`define UCG_OFF_P3_OUTHALF 12'h1a4
`define UCG_OFF_P3_FRAC 12'h1a8
`define UCG_OFF_P4_SRCDIV 12'h1ac
`define UCG_OFF_P4_OUTHALF 12'h1b0
`define UCG_OFF_P4_FRAC 12'h1b4
`define UCG_OFF_P5_SRCDIV 12'h1b8

// ----------------------------------------------------------------
// decoded register ids
// ----------------------------------------------------------------
`define UCG_ID_NONE 4'h0
`define UCG_ID_P2_FRAC 4'h1
`define UCG_ID_P3_SRCDIV 4'h2
`define UCG_ID_P3_OUTHALF 4'h3
`define UCG_ID_P3_FRAC 4'h4
`define UCG_ID_P4_SRCDIV 4'h5
`define UCG_ID_P4_OUTHALF 4'h6
`define UCG_ID_P4_FRAC 4'h7
`define UCG_ID_P5_SRCDIV 4'h8

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UCG_MASK_HI 31
`define UCG_MASK_LO 16
`define UCG_SEL_HI 15
`define UCG_SEL_LO 14
`define UCG_DIV_HI 4
`define UCG_DIV_LO 0
`define UCG_NUM_HI 31
`define UCG_NUM_LO 16
`define UCG_DEN_HI 15
`define UCG_DEN_LO 0

// ----------------------------------------------------------------
// reset values and selector codes
// ----------------------------------------------------------------
`define UCG_RST_SEL 2'h0
`define UCG_RST_DIV 5'h0b
`define UCG_RST_FRAC 32'h0bb8ea60
`define UCG_SRC_GENERAL 2'h0
`define UCG_SRC_CRYSTAL 2'h1
`define UCG_SRC_USBPHY 2'h2
`define UCG_SRC_SECONDARY 2'h3
`define UCG_OUT_INT 2'h0
`define UCG_OUT_HALF 2'h1
`define UCG_OUT_FRAC 2'h2

`endif

// File: design/ucg_top.v
// Design decision made here: the AHB-Lite slave port.
`include "ucg_consts.vh"

module ucg_top (
    // ahb-lite slave
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    // upstream clock enables, one-cycle pulses
    input wire general_pll_clock,
    input wire crystal_osc_input,
    input wire usb_phy_480m_clock,
    input wire secondary_pll_clock,
    // port 2 integer-divided clock enable, made upstream
    input wire port2_int_tick,
    // generated clock enables, one-cycle pulses
    output wire port2_fraction_clock,
    output wire port3_clk_en,
    output wire port4_clk_en,
    output wire port5_int_divided_clock
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function [3:0] ucg_decode;
        input [11:0] addr;
        begin
            if (addr == `UCG_OFF_P2_FRAC) begin
                ucg_decode = `UCG_ID_P2_FRAC;
            end else if (addr == `UCG_OFF_P3_SRCDIV) begin
                ucg_decode = `UCG_ID_P3_SRCDIV;
            end else if (addr == `UCG_OFF_P3_OUTHALF) begin
                ucg_decode = `UCG_ID_P3_OUTHALF;
            end else if (addr == `UCG_OFF_P3_FRAC) begin
                ucg_decode = `UCG_ID_P3_FRAC;
            end else if (addr == `UCG_OFF_P4_SRCDIV) begin
                ucg_decode = `UCG_ID_P4_SRCDIV;
            end else if (addr == `UCG_OFF_P4_OUTHALF) begin
                ucg_decode = `UCG_ID_P4_OUTHALF;
            end else if (addr == `UCG_OFF_P4_FRAC) begin
                ucg_decode = `UCG_ID_P4_FRAC;
            end else if (addr == `UCG_OFF_P5_SRCDIV) begin
                ucg_decode = `UCG_ID_P5_SRCDIV;
            end else begin
                ucg_decode = `UCG_ID_NONE;
            end
        end
    endfunction

    // masked update of a 2-bit field and a 5-bit field
    function [6:0] ucg_masked;
        input [6:0] old;
        input [31:0] wd;
        reg [6:0] m;
        reg [6:0] v;
        begin
            m = {wd[`UCG_MASK_LO+`UCG_SEL_HI:`UCG_MASK_LO+`UCG_SEL_LO],
                 wd[`UCG_MASK_LO+`UCG_DIV_HI:`UCG_MASK_LO+`UCG_DIV_LO]};
            v = {wd[`UCG_SEL_HI:`UCG_SEL_LO], wd[`UCG_DIV_HI:`UCG_DIV_LO]};
            ucg_masked = (old & ~m) | (v & m);
        end
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // index 0..2 = port 3,4,5 for srcdiv; 0..1 = port 3,4 for outhalf
    // index 0..2 = port 2,3,4 for fraction ratio
    reg [6:0] srcdiv_q [0:2];
    reg [6:0] outhalf_q [0:1];
    reg [31:0] frac_q [0:2];
    reg wr_pend_q;
    reg [3:0] wr_id_q;
    wire [3:0] ap_id;
    wire ap_valid;
    reg [31:0] rd_d;
    integer i;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ap_valid = hsel & htrans[1] & hready;
    assign ap_id = ucg_decode(haddr[11:0]);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_id_q <= `UCG_ID_NONE;
        end else begin
            wr_pend_q <= ap_valid & hwrite;
            wr_id_q <= ap_id;
        end
    end

    // read data is formed in the address phase so hrdata leaves a flop
    always @* begin
        rd_d = 32'h00000000;
        case (ap_id)
            `UCG_ID_P2_FRAC: rd_d = frac_q[0];
            `UCG_ID_P3_SRCDIV: rd_d = {16'h0000, srcdiv_q[0][6:5], 9'h000, srcdiv_q[0][4:0]};
            `UCG_ID_P3_OUTHALF: rd_d = {16'h0000, outhalf_q[0][6:5], 9'h000, outhalf_q[0][4:0]};
            `UCG_ID_P3_FRAC: rd_d = frac_q[1];
            `UCG_ID_P4_SRCDIV: rd_d = {16'h0000, srcdiv_q[1][6:5], 9'h000, srcdiv_q[1][4:0]};
            `UCG_ID_P4_OUTHALF: rd_d = {16'h0000, outhalf_q[1][6:5], 9'h000, outhalf_q[1][4:0]};
            `UCG_ID_P4_FRAC: rd_d = frac_q[2];
            `UCG_ID_P5_SRCDIV: rd_d = {16'h0000, srcdiv_q[2][6:5], 9'h000, srcdiv_q[2][4:0]};
            default: rd_d = 32'h00000000;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (ap_valid & ~hwrite) begin
            hrdata <= rd_d;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (i = 0; i < 3; i = i + 1) begin
                srcdiv_q[i] <= {`UCG_RST_SEL, `UCG_RST_DIV};
                frac_q[i] <= `UCG_RST_FRAC;
            end
            for (i = 0; i < 2; i = i + 1) begin
                outhalf_q[i] <= {`UCG_RST_SEL, `UCG_RST_DIV};
            end
        end else if (wr_pend_q) begin
            case (wr_id_q)
                `UCG_ID_P3_SRCDIV: srcdiv_q[0] <= ucg_masked(srcdiv_q[0], hwdata);
                `UCG_ID_P4_SRCDIV: srcdiv_q[1] <= ucg_masked(srcdiv_q[1], hwdata);
                `UCG_ID_P5_SRCDIV: srcdiv_q[2] <= ucg_masked(srcdiv_q[2], hwdata);
                `UCG_ID_P3_OUTHALF: outhalf_q[0] <= ucg_masked(outhalf_q[0], hwdata);
                `UCG_ID_P4_OUTHALF: outhalf_q[1] <= ucg_masked(outhalf_q[1], hwdata);
                `UCG_ID_P2_FRAC: frac_q[0] <= hwdata;
                `UCG_ID_P3_FRAC: frac_q[1] <= hwdata;
                `UCG_ID_P4_FRAC: frac_q[2] <= hwdata;
                default: frac_q[0] <= frac_q[0];
            endcase
        end
    end

    // ----------------------------------------------------------------
    // integer dividers, ports 3..5
    // ----------------------------------------------------------------
    wire [3:0] src_vec;
    wire [2:0] int_tick;
    assign src_vec = {secondary_pll_clock, usb_phy_480m_clock,
                      crystal_osc_input, general_pll_clock};

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_int
            reg [4:0] cnt_q;
            reg tick_q;
            wire src_tick;
            assign src_tick = src_vec[srcdiv_q[g][6:5]];
            // compare with >= so a smaller divisor written mid-count never hangs
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cnt_q <= 5'h00;
                    tick_q <= 1'b0;
                end else begin
                    tick_q <= 1'b0;
                    if (src_tick) begin
                        if (cnt_q >= srcdiv_q[g][4:0]) begin
                            cnt_q <= 5'h00;
                            tick_q <= 1'b1;
                        end else begin
                            cnt_q <= cnt_q + 5'h01;
                        end
                    end
                end
            end
            assign int_tick[g] = tick_q;
        end
    endgenerate

    // ----------------------------------------------------------------
    // half-step dividers, ports 3..4
    // ----------------------------------------------------------------
    wire [1:0] half_tick;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_half
            reg [6:0] acc_q;
            reg tick_q;
            wire [6:0] limit;
            wire [6:0] sum;
            wire [6:0] rem;
            assign limit = {1'b0, outhalf_q[g][4:0], 1'b0} + 7'h03;
            assign sum = acc_q + 7'h02;
            assign rem = sum - limit;
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    acc_q <= 7'h00;
                    tick_q <= 1'b0;
                end else begin
                    tick_q <= 1'b0;
                    if (int_tick[g]) begin
                        if (sum >= limit) begin
                            tick_q <= 1'b1;
                            acc_q <= (rem >= limit) ? 7'h00 : rem;
                        end else begin
                            acc_q <= sum;
                        end
                    end
                end
            end
            assign half_tick[g] = tick_q;
        end
    endgenerate

    // ----------------------------------------------------------------
    // fractional dividers, ports 2..4
    // ----------------------------------------------------------------
    wire [2:0] frac_in;
    wire [2:0] frac_tick;
    assign frac_in = {int_tick[1], int_tick[0], port2_int_tick};
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_frac
            reg [16:0] acc_q;
            reg tick_q;
            wire [16:0] num;
            wire [16:0] den;
            wire [16:0] sum;
            wire [16:0] rem;
            assign num = {1'b0, frac_q[g][`UCG_NUM_HI:`UCG_NUM_LO]};
            assign den = {1'b0, frac_q[g][`UCG_DEN_HI:`UCG_DEN_LO]};
            assign sum = acc_q + num;
            assign rem = sum - den;
            // at most one output per input tick, so num above den saturates
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    acc_q <= 17'h00000;
                    tick_q <= 1'b0;
                end else begin
                    tick_q <= 1'b0;
                    if (frac_in[g] && (den != 17'h00000)) begin
                        if (sum >= den) begin
                            tick_q <= 1'b1;
                            acc_q <= (rem >= den) ? 17'h00000 : rem;
                        end else begin
                            acc_q <= sum;
                        end
                    end
                end
            end
            assign frac_tick[g] = tick_q;
        end
    endgenerate

    // ----------------------------------------------------------------
    // output pick, ports 3..4
    // ----------------------------------------------------------------
    // enables are whole pulses, so a switch can only drop or add a pulse
    wire [1:0] out_tick;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_out
            reg tick_q;
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    tick_q <= 1'b0;
                end else begin
                    case (outhalf_q[g][6:5])
                        `UCG_OUT_INT: tick_q <= int_tick[g];
                        `UCG_OUT_HALF: tick_q <= half_tick[g];
                        `UCG_OUT_FRAC: tick_q <= frac_tick[g + 1];
                        default: tick_q <= 1'b0;
                    endcase
                end
            end
            assign out_tick[g] = tick_q;
        end
    endgenerate

    assign port3_clk_en = out_tick[0];
    assign port4_clk_en = out_tick[1];
    assign port5_int_divided_clock = int_tick[2];
    assign port2_fraction_clock = frac_tick[0];

endmodule

// File: verif/ucg_assertions.sv
module ucg_assertions (
    // bus
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    // clock enables
    input wire general_pll_clock,
    input wire crystal_osc_input,
    input wire usb_phy_480m_clock,
    input wire secondary_pll_clock,
    input wire port2_int_tick,
    input wire port2_fraction_clock,
    input wire port3_clk_en,
    input wire port4_clk_en,
    input wire port5_int_divided_clock
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // helpers
    // ----
    wire take_rd = hsel && htrans[1] && hready && !hwrite;
    wire [11:0] a = haddr[11:0];
    wire msk = a == 12'h1a0 || a == 12'h1a4 || a == 12'h1ac || a == 12'h1b0 || a == 12'h1b8;
    wire unm = a < 12'h19c || a > 12'h1b8;
    wire src = general_pll_clock | crystal_osc_input | usb_phy_480m_clock | secondary_pll_clock;
    reg msk_q;
    reg unm_q;
    // deepest clock path is three stages, so three cycles of history suffice
    reg [2:0] src_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            msk_q <= 1'b0;
            unm_q <= 1'b0;
            src_q <= 3'h0;
        end else begin
            msk_q <= take_rd && msk;
            unm_q <= take_rd && unm;
            src_q <= {src_q[1:0], src};
        end
    end
    // ----
    // properties
    // ----
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ready_high_a: assert property (hreadyout) else $error("hreadyout low");
    resp_okay_a: assert property (!hresp) else $error("hresp not okay");
    mask_reads_zero_a: assert property (msk_q |-> hrdata[31:16] == 16'h0)
        else $error("mask bits read back");
    reserved_zero_a: assert property (msk_q |-> hrdata[13:5] == 9'h0)
        else $error("reserved bits nonzero");
    unmapped_zero_a: assert property (unm_q |-> hrdata == 32'h0)
        else $error("unmapped read nonzero");
    read_hold_a: assert property (!take_rd |=> $stable(hrdata))
        else $error("hrdata moved without read");
    int_after_src_a: assert property (port5_int_divided_clock |-> src_q[0])
        else $error("port5 pulse without source");
    frac_after_tick_a: assert property (port2_fraction_clock |-> $past(port2_int_tick))
        else $error("port2 pulse without tick");
    port3_after_src_a: assert property (port3_clk_en |-> |src_q)
        else $error("port3 pulse without source");
    port4_after_src_a: assert property (port4_clk_en |-> |src_q)
        else $error("port4 pulse without source");
endmodule

bind ucg_top ucg_assertions u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .general_pll_clock(general_pll_clock),
    .crystal_osc_input(crystal_osc_input), .usb_phy_480m_clock(usb_phy_480m_clock),
    .secondary_pll_clock(secondary_pll_clock), .port2_int_tick(port2_int_tick),
    .port2_fraction_clock(port2_fraction_clock), .port3_clk_en(port3_clk_en),
    .port4_clk_en(port4_clk_en), .port5_int_divided_clock(port5_int_divided_clock)
);

// File: verif/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    // bit 0 general, 1 crystal, 2 usb phy, 3 secondary, 4 port2 tick
    logic [4:0] src = 5'h0;
    wire [31:0] hrdata;
    wire hreadyout;
    wire hresp;
    wire [3:0] outs;
    int error_cnt = 0;
    int check_count = 0;
    logic [15:0] cnt [4] = '{default: 16'h0};
    logic [15:0] base [4];
    logic [31:0] rd;
    int pick_exp [4] = '{24, 16, 6, 0};

    ucg_top dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .general_pll_clock(src[0]), .crystal_osc_input(src[1]),
        .usb_phy_480m_clock(src[2]), .secondary_pll_clock(src[3]),
        .port2_int_tick(src[4]), .port2_fraction_clock(outs[0]), .port3_clk_en(outs[1]),
        .port4_clk_en(outs[2]), .port5_int_divided_clock(outs[3])
    );

    initial forever #10 hclk = ~hclk;

    always @(posedge hclk) begin
        for (int i = 0; i < 4; i++) cnt[i] <= cnt[i] + {15'h0, outs[i] === 1'b1};
    end

    // ----
    // tasks
    // ----
    task automatic end_sim();
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // entered just after a rising edge; returns at the edge ending the data phase
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // first pass primes divider phase, second pass is the one counted
    task automatic burst(input logic [4:0] w, input int n);
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 4; i++) base[i] = cnt[i];
            src <= w;
            repeat (n) @(posedge hclk);
            src <= 5'h0;
            repeat (5) @(posedge hclk);
        end
    endtask

    // ----
    // tests
    // ----
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 8; i++) begin
            rdchk(12'h19c + 12'(4 * i), (i % 3 == 0) ? 32'h0bb8ea60 : 32'h0000000b);
        end
        bus(1'b1, 12'h1bc, 32'hffffffff);
        rdchk(12'h1bc, 32'h0);
        burst(5'h01, 24);
        chk(cnt[3] - base[3], 32'h2);
        chk(cnt[1] - base[1], 32'h2);
        bus(1'b1, 12'h1a0, 32'h0000c01f);
        rdchk(12'h1a0, 32'h0000000b);
        bus(1'b1, 12'h1a0, 32'hffffffff);
        rdchk(12'h1a0, 32'h0000c01f);
        bus(1'b1, 12'h1a0, 32'h0001c000);
        rdchk(12'h1a0, 32'h0000c01e);
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 12'h1b8, 32'hc01f0003 | (k << 14));
            burst(5'hf & ~5'(1 << k), 16);
            chk(cnt[3] - base[3], 32'h0);
            burst(5'(1 << k), 16);
            chk(cnt[3] - base[3], 32'h4);
        end
        bus(1'b1, 12'h1a0, 32'hc01f0001);
        bus(1'b1, 12'h1a8, 32'h00010004);
        for (int pk = 0; pk < 4; pk++) begin
            bus(1'b1, 12'h1a4, 32'hc01f0000 | (pk << 14));
            burst(5'h01, 48);
            chk(cnt[1] - base[1], pick_exp[pk]);
        end
        bus(1'b1, 12'h1a8, 32'h00050000);
        rdchk(12'h1a8, 32'h00050000);
        bus(1'b1, 12'h1a4, 32'hc01f8000);
        burst(5'h01, 48);
        chk(cnt[1] - base[1], 32'h0);
        bus(1'b1, 12'h1ac, 32'hc01f4000);
        bus(1'b1, 12'h1b0, 32'hc01f4001);
        burst(5'h02, 30);
        chk(cnt[2] - base[2], 32'hc);
        bus(1'b1, 12'h1b4, 32'h00010002);
        rdchk(12'h1b4, 32'h00010002);
        bus(1'b1, 12'h1b0, 32'hc01f8001);
        burst(5'h02, 30);
        chk(cnt[2] - base[2], 32'hf);
        bus(1'b1, 12'h19c, 32'h00010003);
        burst(5'h10, 24);
        chk(cnt[0] - base[0], 32'h8);
        end_sim();
    end

    // the whole sequence needs about twelve hundred cycles
    initial begin
        #200us;
        error_cnt++;
        end_sim();
    end
endmodule
